// >>> tx_enable_status_manual_ctrl_test.sv
// Self-checking bench for the transmitter front end: registers, status views, manual decode.
// Assumes the register port is driven at the falling edge and read data lags one edge.
module tx_enable_status_manual_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, xtal_enable = 0, reg_write = 0, use_pins = 0, want_en = 0;
	logic want_data = 0, enable_pin, data_pin, modulation_select_pin = 0;
	logic deviation_select_pin = 0, power_select_high_pin = 0, power_select_low_pin = 0;
	logic shaping_resistor_pin = 0, serial_fsk_mode = 0, pll_locked = 0, pa_on = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lfsr = 8'h24;
	logic [2:0] band = 3'h0, clock_divider_setting = 3'h0;
	logic [4:0] serial_pa_tune = 5'h00, emul_pa_tune = 5'h00, current_pa_power = 5'h00;
	logic [15:0] serial_divider = 16'h0000, active_divider;
	logic internal_enable, transmit_data, manual_mode, fsk_mode, fractional_n_mode;
	logic wide_deviation, ramp_active;
	logic [3:0] power_backoff_db;
	logic [15:0] ratios [1:7];
	logic [3:0] db [0:3];
	int err_count = 0, check_count = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Design, pin-driving controller and clock.
	txc_front dut (.clk, .resetn, .xtal_enable, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
		.enable_pin, .data_pin, .band_select_pin_a(band[0]), .band_select_pin_b(band[1]),
		.band_select_pin_c(band[2]), .modulation_select_pin, .deviation_select_pin,
		.power_select_high_pin, .power_select_low_pin, .shaping_resistor_pin,
		.clock_divider_setting, .serial_pa_tune, .emul_pa_tune, .current_pa_power,
		.serial_divider, .serial_fsk_mode, .pll_locked, .pa_on, .internal_enable,
		.transmit_data, .manual_mode, .fsk_mode, .active_divider, .fractional_n_mode,
		.wide_deviation, .power_backoff_db, .ramp_active);
	txc_mcu mcu (.use_pins, .want_en, .want_data, .enable_pin, .data_pin);
	initial begin
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers; all are entered at a falling edge, except wrap_up when the timeout calls it at a rising edge.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1;
		@(negedge clk);
		reg_write = 0;
		// One idle cycle keeps back-to-back writes from toggling the strobe in one step.
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic view(input logic [2:0] s, output logic [7:0] d);
		wr(8'h04, {5'h00, s});
		rd(8'h12, d);
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// A hang is cut short here and counted as a mismatch.
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, register path, status views, manual decode, ramp, clock flag, divided clocks.
	initial begin
		logic [7:0] d;
		logic [7:0] prev;
		int i;
		int t4 = 0, t16 = 0, tout = 0;
		ratios = '{txc_pkg::RATIO_1, txc_pkg::RATIO_2, txc_pkg::RATIO_3, txc_pkg::RATIO_4,
			txc_pkg::RATIO_5, txc_pkg::RATIO_6, txc_pkg::RATIO_7};
		db = '{4'h0, 4'h3, 4'h6, 4'ha};
		repeat (2) @(negedge clk);
		resetn = 1;
		rd(8'h10, d);
		check("enable reg", d, 8'h00);
		rd(8'h11, d);
		check("data reg", d, 8'h00);
		view(3'h0, d);
		check("no clock flag", d[0], 1'b1);
		wr(8'h10, 8'h01);
		check("enable from bit", internal_enable, 1'b1);
		wr(8'h11, 8'h01);
		check("data from bit", transmit_data, 1'b1);
		// A reset in mid-run must clear bits that were written.
		resetn = 0;
		repeat (2) @(negedge clk);
		resetn = 1;
		rd(8'h10, d);
		check("enable after reset", d, 8'h00);
		rd(8'h11, d);
		check("data after reset", d, 8'h00);
		use_pins = 1;
		want_en = 1;
		want_data = 1;
		view(3'h2, d);
		repeat (5) @(negedge clk);
		check("enable from pin", internal_enable, 1'b1);
		check("data from pin", transmit_data, 1'b1);
		view(3'h2, d);
		check("enable view", d, 8'h08);
		want_en = 0;
		want_data = 0;
		wr(8'h12, 8'hff);
		view(3'h1, d);
		check("empty view", d, 8'h00);
		rd(8'h3f, d);
		check("unmapped read", d, 8'h00);
		for (i = 0; i < 8; i++) begin
			{serial_pa_tune, serial_fsk_mode, pll_locked, pa_on} = rnd();
			{emul_pa_tune, clock_divider_setting} = rnd();
			current_pa_power = (i == 0) ? 5'h00 : 5'(rnd());
			serial_divider = (i == 0) ? {rnd(), 8'h00} & 16'hf000 : {rnd(), rnd()};
			if (i == 0) serial_fsk_mode = 0;
			view(3'h3, d);
			check("tune view", d, {1'b0, serial_fsk_mode | (|serial_divider[11:0]), 1'b0,
				serial_pa_tune});
			view(3'h4, d);
			check("emul view", d, {2'b00, |current_pa_power, emul_pa_tune});
			view(3'h5, d);
			check("divider high", d, serial_divider[15:8]);
			view(3'h6, d);
			check("divider low", d, serial_divider[7:0]);
			view(3'h7, d);
			check("lock view", d, {6'h00, pll_locked, pa_on});
		end
		for (i = 1; i < 8; i++) begin
			band = i[2:0];
			modulation_select_pin = i[0];
			deviation_select_pin = i[1];
			{power_select_high_pin, power_select_low_pin} = i[1:0];
			repeat (6) @(negedge clk);
			check("manual mode", manual_mode, 1'b1);
			check("ratio", active_divider, ratios[i]);
			check("modulation", fsk_mode, i[0]);
			check("deviation", wide_deviation, i[1]);
			check("backoff", power_backoff_db, db[i[1:0]]);
		end
		band = 3'h1;
		modulation_select_pin = 0;
		shaping_resistor_pin = 1;
		pa_on = 0;
		repeat (6) @(negedge clk);
		pa_on = 1;
		repeat (4) @(negedge clk);
		check("ramp running", ramp_active, 1'b1);
		repeat (260) @(negedge clk);
		check("ramp ended", ramp_active, 1'b0);
		band = 3'h0;
		repeat (6) @(negedge clk);
		check("serial mode", manual_mode, 1'b0);
		xtal_enable = 1;
		view(3'h0, d);
		for (i = 0; i < 300 && d[0] === 1'b1; i++) rd(8'h12, d);
		check("clock seen", d[0], 1'b0);
		// Edges of the divided clocks over sixteen cycles, independent of their phase.
		clock_divider_setting = 3'h2;
		repeat (4) @(negedge clk);
		rd(8'h12, d);
		for (i = 0; i < 16; i++) begin
			prev = d;
			rd(8'h12, d);
			t4 += int'(d[1] != prev[1]);
			t16 += int'(d[2] != prev[2]);
			tout += int'(d[3] != prev[3]);
		end
		check("div4 edges", 16'(t4), 16'h0008);
		check("div16 edges", 16'(t16), 16'h0002);
		check("clock out edges", 16'(tout), 16'h0004);
		wrap_up();
	end
endmodule

// >>> txc_front.sv
// Register bank, status multiplexer and manual-mode pin decode of the transmitter.
// Assumes the serial core presents one-cycle write strobes and a byte address; pins are async.
module txc_front #(
	parameter int CKDIV_W = 3
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic xtal_enable,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic enable_pin,
	input wire logic data_pin,
	input wire logic band_select_pin_a,
	input wire logic band_select_pin_b,
	input wire logic band_select_pin_c,
	input wire logic modulation_select_pin,
	input wire logic deviation_select_pin,
	input wire logic power_select_high_pin,
	input wire logic power_select_low_pin,
	input wire logic shaping_resistor_pin,
	input wire logic [CKDIV_W-1:0] clock_divider_setting,
	input wire logic [4:0] serial_pa_tune,
	input wire logic [4:0] emul_pa_tune,
	input wire logic [4:0] current_pa_power,
	input wire logic [15:0] serial_divider,
	input wire logic serial_fsk_mode,
	input wire logic pll_locked,
	input wire logic pa_on,
	output logic internal_enable,
	output logic transmit_data,
	output logic manual_mode,
	output logic fsk_mode,
	output logic [15:0] active_divider,
	output logic fractional_n_mode,
	output logic wide_deviation,
	output logic [3:0] power_backoff_db,
	output logic ramp_active
);
	localparam int NPIN = 10;
	localparam int RAMP_W = $clog2(txc_pkg::RAMP_CYCLES + 1);

	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [NPIN-1:0] s3;
		logic [NPIN-1:0] pins;
		logic enable_bit;
		logic data_bit;
		logic [2:0] status_select;
		logic [15:0] prescale;
		logic [7:0] nock_count;
		logic osc_absent;
		logic clock_out;
		logic [RAMP_W-1:0] ramp;
		logic last_pa;
		logic [7:0] rdata;
	} txc_state_t;

	txc_state_t st;
	txc_state_t next_st;
	logic [NPIN-1:0] raw_pins;
	logic [2:0] band;
	logic [7:0] view;

	// Raw pin vector ahead of the three-stage filter; the data pin goes through it as well.
	assign raw_pins = {data_pin, shaping_resistor_pin, power_select_low_pin, power_select_high_pin,
		deviation_select_pin, modulation_select_pin, band_select_pin_c, band_select_pin_b,
		band_select_pin_a, enable_pin};
	// Pull-downs live in the pad ring, so an open pin arrives here as zero.
	// default serial
	assign band = st.pins[3:1];

	// Shared decode of band code to divide ratio; code 000 keeps the serial value.
	function automatic logic [15:0] txc_ratio(input logic [2:0] code, input logic [15:0] dflt);
		case (code)
			3'h1: txc_ratio = txc_pkg::RATIO_1;
			3'h2: txc_ratio = txc_pkg::RATIO_2;
			3'h3: txc_ratio = txc_pkg::RATIO_3;
			3'h4: txc_ratio = txc_pkg::RATIO_4;
			3'h5: txc_ratio = txc_pkg::RATIO_5;
			3'h6: txc_ratio = txc_pkg::RATIO_6;
			3'h7: txc_ratio = txc_pkg::RATIO_7;
			default: txc_ratio = dflt;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Manual-mode decode.
	// any band high
	assign manual_mode = |band;
	assign active_divider = txc_ratio(band, serial_divider);
	assign fsk_mode = manual_mode ? st.pins[4] : serial_fsk_mode;
	assign wide_deviation = manual_mode & st.pins[5];
	// power pin decode
	// The high power pin is the upper bit of the code, the low power pin the lower bit.
	always_comb begin
		case ({st.pins[6], st.pins[7]})
			2'b00: power_backoff_db = txc_pkg::PWR_DB_0;
			2'b01: power_backoff_db = txc_pkg::PWR_DB_1;
			2'b10: power_backoff_db = txc_pkg::PWR_DB_2;
			default: power_backoff_db = txc_pkg::PWR_DB_3;
		endcase
	end
	// fixed-N only for ASK with zero fraction
	assign fractional_n_mode = fsk_mode | (|active_divider[11:0]);
	assign internal_enable = st.pins[0] | st.enable_bit;
	// data source; unused source is held low by the controller
	assign transmit_data = st.pins[9] | st.data_bit;
	assign ramp_active = st.ramp != '0;
	assign reg_rdata = st.rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Status view selection; unassigned bits and view 1 stay zero.
	always_comb begin
		view = txc_pkg::RESET_BYTE;
		case (st.status_select)
			txc_pkg::SEL_CLOCKS: view[3:0] = {st.clock_out, st.prescale[txc_pkg::DIV16_LOG-1],
				st.prescale[txc_pkg::DIV4_LOG-1], st.osc_absent};
			txc_pkg::SEL_ENABLE: view[3] = internal_enable;
			txc_pkg::SEL_SERIAL_TUNE: view = {1'b0, fractional_n_mode, 1'b0, serial_pa_tune};
			txc_pkg::SEL_EMUL_TUNE: view = {2'b00, |current_pa_power, emul_pa_tune};
			txc_pkg::SEL_DIV_HIGH: view = active_divider[15:8];
			txc_pkg::SEL_DIV_LOW: view = active_divider[7:0];
			txc_pkg::SEL_LOCK: view[1:0] = {pll_locked, pa_on};
			default: view = txc_pkg::RESET_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole block.
	always_comb begin
		next_st = st;
		next_st.s1 = raw_pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// A pin change is accepted only when the second and third stages agree.
		for (int i = 0; i < NPIN; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.pins[i] = st.s3[i];
			end
		end
		if (reg_write) begin
			case (reg_addr)
				txc_pkg::ADDR_TRANSMIT_ENABLE: next_st.enable_bit = reg_wdata[0];
				txc_pkg::ADDR_TRANSMIT_DATA_BIT: next_st.data_bit = reg_wdata[0];
				txc_pkg::ADDR_IO_CONFIG: next_st.status_select = reg_wdata[2:0];
				default: ;
			endcase
		end
		case (reg_addr)
			txc_pkg::ADDR_TRANSMIT_ENABLE: next_st.rdata = {7'h00, st.enable_bit};
			txc_pkg::ADDR_TRANSMIT_DATA_BIT: next_st.rdata = {7'h00, st.data_bit};
			txc_pkg::ADDR_IO_CONFIG: next_st.rdata = {5'h00, st.status_select};
			txc_pkg::ADDR_SELECTED_STATUS: next_st.rdata = view;
			default: next_st.rdata = txc_pkg::RESET_BYTE;
		endcase
		if (xtal_enable) begin
			next_st.prescale = st.prescale + 16'h0001;
			next_st.clock_out = st.prescale[clock_divider_setting];
			if (st.nock_count != 8'(txc_pkg::NOCK_LIMIT)) begin
				next_st.nock_count = st.nock_count + 8'h01;
			end else begin
				next_st.osc_absent = 1'b0;
			end
		end else begin
			next_st.nock_count = 8'h00;
			next_st.osc_absent = 1'b1;
		end
		// restart ramp on PA edge in manual ASK with analog shaping
		next_st.last_pa = pa_on;
		if (manual_mode && !fsk_mode && st.pins[8] && (pa_on != st.last_pa)) begin
			next_st.ramp = RAMP_W'(txc_pkg::RAMP_CYCLES);
		end else if (st.ramp != '0) begin
			next_st.ramp = st.ramp - RAMP_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; reset leaves transmission disabled.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st <= '0;
			st.osc_absent <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_status_read;
		reg_addr == txc_pkg::ADDR_SELECTED_STATUS;
	endsequence
	property p_or_enable;
		@(posedge clk) disable iff (!resetn) internal_enable == (st.pins[0] | st.enable_bit);
	endproperty
	a_or_enable: assert property (p_or_enable)
		else $error("Enable is not the OR of sources.");
	property p_select_one_zero;
		@(posedge clk) disable iff (!resetn)
			s_status_read and (st.status_select == 3'h1) |=> reg_rdata == 8'h00;
	endproperty
	a_select_one_zero: assert property (p_select_one_zero)
		else $error("View one not zero.");
	property p_lock_view;
		@(posedge clk) disable iff (!resetn)
			s_status_read and (st.status_select == 3'h7) |=>
			reg_rdata == {6'h00, $past(pll_locked), $past(pa_on)};
	endproperty
	a_lock_view: assert property (p_lock_view)
		else $error("Lock view wrong.");
	property p_manual;
		@(posedge clk) disable iff (!resetn) manual_mode == (st.pins[3:1] != 3'h0);
	endproperty
	a_manual: assert property (p_manual)
		else $error("Manual mode decode wrong.");
	property p_nock;
		@(posedge clk) disable iff (!resetn) !xtal_enable |=> st.osc_absent;
	endproperty
	a_nock: assert property (p_nock)
		else $error("Oscillator-absent flag not set.");
	// The flag must drop once the activity counter has run its full length.
	property p_osc_clear;
		@(posedge clk) disable iff (!resetn)
			xtal_enable && st.nock_count == 8'hff |=> !st.osc_absent;
	endproperty
	a_osc_clear: assert property (p_osc_clear)
		else $error("Oscillator-absent flag not cleared.");
	property p_ratio_seven;
		@(posedge clk) disable iff (!resetn) band == 3'h7 |-> active_divider == 16'hb1ec;
	endproperty
	a_ratio_seven: assert property (p_ratio_seven)
		else $error("Ratio for code 7 wrong.");
	property p_power;
		@(posedge clk) disable iff (!resetn) st.pins[7:6] == 2'b11 |-> power_backoff_db == 4'ha;
	endproperty
	a_power: assert property (p_power)
		else $error("Power decode wrong.");
	// The high power pin alone is the 6 dB setting; this catches swapped pin order.
	property p_power_order;
		@(posedge clk) disable iff (!resetn)
			st.pins[6] && !st.pins[7] |-> power_backoff_db == 4'h6;
	endproperty
	a_power_order: assert property (p_power_order)
		else $error("Power pin order wrong.");
	property p_status_ro;
		@(posedge clk) disable iff (!resetn)
			reg_write && reg_addr == txc_pkg::ADDR_SELECTED_STATUS |=> $stable(st.status_select);
	endproperty
	a_status_ro: assert property (p_status_ro)
		else $error("Status write had effect.");
	property p_reset_bits;
		@(posedge clk) !resetn |=> !st.enable_bit && !st.data_bit;
	endproperty
	a_reset_bits: assert property (p_reset_bits)
		else $error("Bits not cleared by reset.");
endmodule

// >>> txc_mcu.sv
// Controller model that drives the enable and data pins of the transmitter front end.
// Assumes the bench says which enable and data source is in use and does register writes itself.
module txc_mcu (
	input wire logic use_pins,
	input wire logic want_en,
	input wire logic want_data,
	output logic enable_pin,
	output logic data_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	// one source only
	// The pins stay low while the register bits carry enable and data, so the OR never mixes them.
	assign enable_pin = use_pins & want_en;
	assign data_pin = use_pins & want_data;
endmodule

// >>> txc_pkg.sv
// Constants for the transmitter control front end: register map, status views, manual decode.
// Assumes a register port of plain address, write strobe and read data driven by the serial core.
// Behaviour
// - Internal enable is pin OR bit.
// - Data bit replaces data pin input; the code ORs pin and bit instead.
// - Eight-bit read-only status, eight selectable views.
// - View 0 shows clocks and oscillator-absent flag.
// - Oscillator-absent flag clears on clock activity.
// - Clock output is crystal divided by setting.
// - Views 3 and 2: tuning, mode, enable.
// - Mode flag one means fractional-N.
// - View 4: emulation tuning, shaping flag.
// - Shaping flag set when power nonzero.
// - Views 5 and 6 show divider parts.
// - View 7 shows lock and PA-on.
// - Any band pin high means manual mode.
// - Band pins pulled down by default.
// - Band codes map to seven divide ratios.
// - Modulation pin selects ASK or FSK.
// - Manual ASK analog ramp about 1us.
// - Manual mode uses data and enable pins.
// - Deviation pin selects 32 or 100 kHz.
// - Power pins decode 0/3/6/10 dB down.
// - Status select held in IO config bits.
package txc_pkg;
	localparam logic [7:0] ADDR_IO_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_TRANSMIT_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_TRANSMIT_DATA_BIT = 8'h11;
	localparam logic [7:0] ADDR_SELECTED_STATUS = 8'h12;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int SEL_W = 3;
	localparam logic [2:0] SEL_CLOCKS = 3'h0;
	localparam logic [2:0] SEL_ENABLE = 3'h2;
	localparam logic [2:0] SEL_SERIAL_TUNE = 3'h3;
	localparam logic [2:0] SEL_EMUL_TUNE = 3'h4;
	localparam logic [2:0] SEL_DIV_HIGH = 3'h5;
	localparam logic [2:0] SEL_DIV_LOW = 3'h6;
	localparam logic [2:0] SEL_LOCK = 3'h7;
	// Divide ratios as integer part (4 bits, offset 16 removed) and 12-bit fraction.
	localparam logic [15:0] RATIO_1 = 16'h3b00; // 19.68750
	localparam logic [15:0] RATIO_2 = 16'hb19f; // 27.10125
	localparam logic [15:0] RATIO_3 = 16'h8600; // 24.37500
	localparam logic [15:0] RATIO_4 = 16'ha200; // 26.12500
	localparam logic [15:0] RATIO_5 = 16'h7400; // 23.25000
	localparam logic [15:0] RATIO_6 = 16'h5900; // 21.56250
	localparam logic [15:0] RATIO_7 = 16'hb1ec; // 27.12000
	localparam int DEV_LOW_KHZ = 32;
	localparam int DEV_HIGH_KHZ = 100;
	localparam logic [3:0] PWR_DB_0 = 4'h0;
	localparam logic [3:0] PWR_DB_1 = 4'h3;
	localparam logic [3:0] PWR_DB_2 = 4'h6;
	localparam logic [3:0] PWR_DB_3 = 4'ha;
	localparam int RAMP_NS = 1000;
	localparam int CLK_NS = 4;
	localparam int RAMP_CYCLES = RAMP_NS / CLK_NS;
	localparam int DIV4_LOG = 2;
	localparam int DIV16_LOG = 4;
	localparam int PRESCALE_W = 8;
	localparam int NOCK_LIMIT = 255;
endpackage
